/* logic/sfr_cfg.svh */
// constants for the sensor fault response manager
// assumes a 100 MHz system clock
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
// register byte offsets
`define SFR_OFF_FLAGS    12'h000
`define SFR_OFF_CFG      12'h004
`define SFR_OFF_MEMCTL   12'h008
`define SFR_OFF_MEMRESP  12'h00c
`define SFR_OFF_STATUS   12'h010
// configuration field positions
`define SFR_CFG_OVD_OFF  0
`define SFR_CFG_REF_OFF  1
`define SFR_CFG_TMP_OFF  2
`define SFR_CFG_OOR_OFF  3
`define SFR_CFG_DMODE    4
`define SFR_CFG_PORDM    5
`define SFR_CFG_SENT     6
`define SFR_CFG_SPM_LO   8
`define SFR_CFG_LOCK_LO  12
// reset values
`define SFR_CFG_RESET    32'h0000_0200
// memory response layout
`define SFR_MEM_DATA_W   26
`define SFR_MEM_SEC_BIT  28
`define SFR_MEM_DED_BIT  29
// lock codes that allow overvoltage reporting
`define SFR_LOCK_A       4'h6
`define SFR_LOCK_B       4'hc
// duty codes in tenths of a percent
`define SFR_DUTY_OV      10'h194
`define SFR_DUTY_UV      10'h074
`define SFR_DUTY_SPM     10'h134
`define SFR_DUTY_OT      10'h1f4
`define SFR_DUTY_LT      10'h254
`define SFR_DUTY_OORL    10'h2b4
`define SFR_DUTY_OORH    10'h314
// timing
`define SFR_CLK_NS       10
`define SFR_UV_HOLD_MS   8
`define SFR_UV_HOLD_CYC  (`SFR_UV_HOLD_MS * 1000000 / `SFR_CLK_NS)
`define SFR_PO_US        2000
`define SFR_PO_CYC       (`SFR_PO_US * 1000 / `SFR_CLK_NS)
`endif

/* logic/sfr_pkg.sv */
// types for the sensor fault response manager
// assumes sfr_cfg.svh supplies the numbers
package sfr_pkg;
    typedef enum logic [1:0] {
        SFR_OUT_NORMAL = 2'b00,
        SFR_OUT_DIAG   = 2'b01,
        SFR_OUT_HIZ    = 2'b10
    } sfr_omode_t;
    typedef struct packed {
        logic uv;
        logic por;
        logic ov;
        logic hv;
        logic ot;
        logic lt;
        logic spm;
        logic oorl;
        logic oorh;
        logic sec;
        logic ded;
    } sfr_faults_t;
endpackage

/* logic/sfr_fault_mgr.sv */
// sensor fault response manager: faults to output mode and flags
// assumes fault inputs synchronous to I_CLK_SYS, AXI4-Lite master
//
// Contract
// (R1) undervoltage forces configured diagnostic output state
// (R2) supply recovery clears undervoltage, output normal
// (R3) below reset level output high impedance
// (R4) withhold normal data until power-on delay
// (R5) post-reset mode zero: output active immediately
// (R6) post-reset mode one: hold undervoltage 8 ms
// (R7) overvoltage with hysteresis forces configured state
// (R8) overvoltage detection only when memory locked
// (R9) high supply unlocked: programming mode, high impedance
// (R10) high-voltage threshold always forces high impedance
// (R11) temperature outside -55..160 C flagged
// (R12) single-bit memory errors corrected transparently
// (R13) double-bit error: high impedance, flag bit 0
// (R14) memory response data 0..25, zeros above
// (R15) response bit 28 corrected, bit 29 double
// (R16) overvoltage: enabled, lock 6/12, 40.4%, bit 4
// (R17) undervoltage: reference enabled, 11.6%, bit 3
// (R18) path monitor cfg 0..2: 30.8%, bit 2
// (R19) thermal: hot 50%, cold 59.6%, bit 5
// (R20) range: low 69.2% bit 6, high 78.8% bit 7
// (R21) SENT status bit0 monitor, bit1 others
// (R22) each diagnostic enabled; response diag or hiz
// (R23) sample faults, update on next edge; overvoltage code and double-error response update one edge later
`timescale 1ns/100ps
`include "sfr_cfg.svh"
module sfr_fault_mgr #(
    parameter int UV_HOLD_CYC = `SFR_UV_HOLD_CYC,
    parameter int PO_CYC      = `SFR_PO_CYC
) (
    // clock and reset
    input  wire logic                 I_CLK_SYS,
    input  wire logic                 I_RST,
    // fault indications from analog monitors and memory
    input  wire sfr_pkg::sfr_faults_t I_FAULTS,
    input  wire logic [25:0]          I_MEM_DATA,
    input  wire logic                 I_MEM_VALID,
    // output behaviour
    output logic [1:0]                O_OUT_MODE,
    output logic [9:0]                O_DUTY_CODE,
    output logic [3:0]                O_SENT_STATUS_NIBBLE,
    output logic                      O_PROG_MODE,
    output logic                      O_MEM_RD_REQ,
    // AXI4-Lite slave
    input  wire logic [11:0]          S_AXI_AWADDR,
    input  wire logic                 S_AXI_AWVALID,
    output logic                      S_AXI_AWREADY,
    input  wire logic [31:0]          S_AXI_WDATA,
    input  wire logic [3:0]           S_AXI_WSTRB,
    input  wire logic                 S_AXI_WVALID,
    output logic                      S_AXI_WREADY,
    output logic [1:0]                S_AXI_BRESP,
    output logic                      S_AXI_BVALID,
    input  wire logic                 S_AXI_BREADY,
    input  wire logic [11:0]          S_AXI_ARADDR,
    input  wire logic                 S_AXI_ARVALID,
    output logic                      S_AXI_ARREADY,
    output logic [31:0]               S_AXI_RDATA,
    output logic [1:0]                S_AXI_RRESP,
    output logic                      S_AXI_RVALID,
    input  wire logic                 S_AXI_RREADY
);
    sfr_pkg::sfr_faults_t f_q;
    logic [31:0]          cfg_q;
    logic [31:0]          mem_resp_q;
    logic [7:0]           flags_q;
    logic                 uv_hold_q;
    logic                 ov_q;
    logic                 ded_q;
    logic [22:0]          hold_cnt_q;
    logic [22:0]          po_cnt_q;
    logic                 po_done_q;
    logic [11:0]          awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 aw_have_q;
    logic                 w_have_q;
    logic                 mem_pend_q;
    sfr_pkg::sfr_omode_t  mode_d;
    logic [9:0]           duty_d;
    logic [3:0]           nib_d;
    logic [7:0]           flags_d;
    logic                 ov_en;
    logic                 uv_en;
    logic                 spm_en;
    logic                 tmp_en;
    logic                 oor_en;
    logic                 uv_eff;
    logic                 locked;
    logic [3:0]           lock_code;
    logic [3:0]           spm_cfg;
    logic                 prog_cond;

    // checks share the system clock and drop out while reset is high
    default clocking cb_sys @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RST);

    // only the full lock code blocks programming entry; code 6 still reports
    assign prog_cond = f_q.ov && (lock_code != `SFR_LOCK_B);    // R9
    assign lock_code = cfg_q[`SFR_CFG_LOCK_LO +: 4];
    assign spm_cfg   = cfg_q[`SFR_CFG_SPM_LO +: 4];
    assign locked    = (lock_code == `SFR_LOCK_A) ||
                       (lock_code == `SFR_LOCK_B);
    // per-diagnostic enables from the configuration word
    assign ov_en  = locked && !cfg_q[`SFR_CFG_OVD_OFF];        // R8 R16 R22
    assign uv_en  = !cfg_q[`SFR_CFG_REF_OFF];                  // R17 R22
    assign spm_en = (spm_cfg <= 4'h2);                         // R18 R22
    assign tmp_en = !cfg_q[`SFR_CFG_TMP_OFF];                  // R19 R22
    assign oor_en = !cfg_q[`SFR_CFG_OOR_OFF];                  // R20 R22

    // fault sampling: one register stage, decisions act a cycle later
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            f_q <= '0;
        end else begin
            f_q <= I_FAULTS;                                   // R23
        end
    end

    // overvoltage latch; analog comparator supplies hysteresis
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            ov_q <= 1'b0;
        end else begin
            ov_q <= f_q.ov;                                    // R7
        end
    end

    // double-bit error is sticky until reset: config can't be trusted
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            ded_q <= 1'b0;
        end else if (f_q.ded) begin
            ded_q <= 1'b1;                                     // R13
        end
    end

    // undervoltage stretch after recovery when post-reset mode is one
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            uv_hold_q  <= 1'b0;
            hold_cnt_q <= '0;
        end else if (f_q.uv) begin
            uv_hold_q  <= cfg_q[`SFR_CFG_PORDM];               // R6
            hold_cnt_q <= 23'(UV_HOLD_CYC - 1);
        end else if (uv_hold_q) begin
            if (hold_cnt_q == '0) begin
                uv_hold_q <= 1'b0;                             // R2
            end else begin
                hold_cnt_q <= hold_cnt_q - 23'h1;
            end
        end
    end
    // mode zero: error follows the monitor directly
    assign uv_eff = f_q.uv || uv_hold_q;                       // R5

    // power-on delay restarts on every reset event
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            po_cnt_q  <= '0;
            po_done_q <= 1'b0;
        end else if (f_q.por) begin
            po_cnt_q  <= '0;
            po_done_q <= 1'b0;                                 // R4
        end else if (!po_done_q) begin
            if (po_cnt_q == 23'(PO_CYC - 1)) begin
                po_done_q <= 1'b1;
            end else begin
                po_cnt_q <= po_cnt_q + 23'h1;
            end
        end
    end

    // priority: hiz causes except the power-on delay, then diagnostic codes in table order
    always_comb begin
        mode_d  = sfr_pkg::SFR_OUT_NORMAL;
        duty_d  = 10'h000;
        nib_d   = 4'h0;
        flags_d = 8'h00;
        if (ov_en && ov_q) begin
            flags_d[4] = 1'b1;                                 // R16
            duty_d     = `SFR_DUTY_OV;
        end else if (uv_en && uv_eff) begin
            flags_d[3] = 1'b1;                                 // R17 R1
            duty_d     = `SFR_DUTY_UV;
        end else if (spm_en && f_q.spm) begin
            flags_d[2] = 1'b1;                                 // R18
            duty_d     = `SFR_DUTY_SPM;
        end else if (tmp_en && (f_q.ot || f_q.lt)) begin
            flags_d[5] = 1'b1;                                 // R11 R19
            duty_d     = f_q.ot ? `SFR_DUTY_OT : `SFR_DUTY_LT;
        end else if (oor_en && f_q.oorl) begin
            flags_d[6] = 1'b1;                                 // R20
            duty_d     = `SFR_DUTY_OORL;
        end else if (oor_en && f_q.oorh) begin
            flags_d[7] = 1'b1;                                 // R20
            duty_d     = `SFR_DUTY_OORH;
        end
        nib_d[0] = flags_d[2];                                 // R21
        nib_d[1] = |{flags_d[7:5], flags_d[4:3]};              // R21
        if (flags_d != 8'h00) begin
            // R22: response may be the code or a released line
            mode_d = cfg_q[`SFR_CFG_DMODE] ? sfr_pkg::SFR_OUT_HIZ
                                           : sfr_pkg::SFR_OUT_DIAG;
        end else if (!po_done_q) begin
            mode_d = sfr_pkg::SFR_OUT_HIZ;                     // R4
        end
        if (ded_q) begin
            flags_d[0] = 1'b1;                                 // R13
            mode_d     = sfr_pkg::SFR_OUT_HIZ;
        end
        if (prog_cond) begin
            mode_d = sfr_pkg::SFR_OUT_HIZ;                     // R9
        end
        if (f_q.por || f_q.hv) begin
            mode_d = sfr_pkg::SFR_OUT_HIZ;                     // R3 R10
        end
    end

    // outputs registered one edge after sampling
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            O_OUT_MODE           <= sfr_pkg::SFR_OUT_HIZ;
            O_DUTY_CODE          <= 10'h000;
            O_SENT_STATUS_NIBBLE <= 4'h0;
            O_PROG_MODE          <= 1'b0;
            flags_q              <= 8'h00;
        end else begin
            O_OUT_MODE           <= mode_d;                    // R23
            O_DUTY_CODE          <= duty_d;
            O_SENT_STATUS_NIBBLE <= nib_d;
            O_PROG_MODE          <= prog_cond;                 // R9
            flags_q              <= flags_d;
        end
    end

    // memory read response; ECC corrects single errors upstream
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            mem_resp_q <= 32'h0000_0000;
            mem_pend_q <= 1'b0;
        end else begin
            if (I_MEM_VALID) begin
                mem_resp_q <= {2'b00, I_FAULTS.ded, I_FAULTS.sec,  // R15
                               2'b00, I_MEM_DATA};             // R12 R14
            end
            // a new request in the same cycle as a return stays pending
            if (O_MEM_RD_REQ) begin
                mem_pend_q <= 1'b1;
            end else if (I_MEM_VALID) begin
                mem_pend_q <= 1'b0;
            end
        end
    end

    // AXI write: address and data accepted in either order
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 12'h000;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= 2'b00;
            cfg_q         <= `SFR_CFG_RESET;
            O_MEM_RD_REQ  <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY &&
                             !S_AXI_BVALID;
            S_AXI_WREADY  <= !w_have_q && !S_AXI_WREADY &&
                             !S_AXI_BVALID;
            O_MEM_RD_REQ  <= 1'b0;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_q <= 1'b1;
                wdata_q  <= S_AXI_WDATA;
                wstrb_q  <= S_AXI_WSTRB;
            end
            if (aw_have_q && w_have_q && !S_AXI_BVALID) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= 2'b00;
                if (awaddr_q[11:2] == `SFR_OFF_CFG >> 2) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wstrb_q[b]) begin
                            cfg_q[8*b +: 8] <= wdata_q[8*b +: 8];
                        end
                    end
                end else if (awaddr_q[11:2] == `SFR_OFF_MEMCTL >> 2) begin
                    O_MEM_RD_REQ <= wdata_q[0] && wstrb_q[0];
                end else if (awaddr_q[11:2] != `SFR_OFF_FLAGS >> 2 &&
                             awaddr_q[11:2] != `SFR_OFF_MEMRESP >> 2 &&
                             awaddr_q[11:2] != `SFR_OFF_STATUS >> 2) begin
                    S_AXI_BRESP <= 2'b10;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // AXI read: one outstanding, unmapped answers SLVERR with zero
    always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
        if (I_RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= 2'b00;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= 2'b00;
                unique case (S_AXI_ARADDR)
                    `SFR_OFF_FLAGS:   S_AXI_RDATA <= {24'h0, flags_q};
                    `SFR_OFF_CFG:     S_AXI_RDATA <= cfg_q;
                    `SFR_OFF_MEMCTL:  S_AXI_RDATA <= {31'h0, mem_pend_q};
                    `SFR_OFF_MEMRESP: S_AXI_RDATA <= mem_resp_q;
                    `SFR_OFF_STATUS:  S_AXI_RDATA <= {26'h0, ded_q,
                        uv_hold_q, po_done_q, O_PROG_MODE, O_OUT_MODE};
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= 2'b10;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // checks
    a_hv_hiz: assert property (f_q.hv |=>  // R10
        O_OUT_MODE == sfr_pkg::SFR_OUT_HIZ)
        else $error("high voltage did not release output");
    a_por_hiz: assert property (f_q.por |=>  // R3
        O_OUT_MODE == sfr_pkg::SFR_OUT_HIZ)
        else $error("reset level did not release output");
    a_ded_flag: assert property (f_q.ded |=> ##1  // R13
        (flags_q[0] && O_OUT_MODE == sfr_pkg::SFR_OUT_HIZ))
        else $error("double error not flagged");
    a_ov_flag: assert property ((ov_q && ov_en) |=>  // R16
        flags_q[4] && O_DUTY_CODE == `SFR_DUTY_OV)
        else $error("overvoltage code wrong");
    a_ov_lock: assert property (!locked |=> !flags_q[4])  // R8
        else $error("overvoltage flagged while unlocked");
    a_prog_mode: assert property (prog_cond |=>  // R9
        O_PROG_MODE && O_OUT_MODE == sfr_pkg::SFR_OUT_HIZ)
        else $error("programming mode missed");
    a_spm_code: assert property (  // R18
        (spm_en && f_q.spm && !(ov_en && ov_q) && !(uv_en && uv_eff)) |=>
            flags_q[2] && O_DUTY_CODE == `SFR_DUTY_SPM)
        else $error("path monitor code wrong");
    a_sent_spm: assert property (  // R21
        O_SENT_STATUS_NIBBLE[0] == flags_q[2])
        else $error("status nibble bit 0 mismatch");
    a_uv_hold: assert property (  // R6
        ($fell(f_q.uv) && cfg_q[`SFR_CFG_PORDM] && uv_en) |=>
            flags_q[3] [*3])
        else $error("undervoltage not held");
    a_uv_clear: assert property (  // R5
        ($fell(f_q.uv) && !uv_hold_q && !cfg_q[`SFR_CFG_PORDM]) |=>
            !flags_q[3])
        else $error("undervoltage not cleared");
    a_mem_hi: assert property (  // R14
        mem_resp_q[31:30] == 2'b00 && mem_resp_q[27:26] == 2'b00)
        else $error("memory response high bits set");
    c_prog: cover property (@(posedge I_CLK_SYS) O_PROG_MODE);
    c_ov: cover property (@(posedge I_CLK_SYS) flags_q[4]);
    c_uv: cover property (@(posedge I_CLK_SYS) flags_q[3]);
    c_ded: cover property (@(posedge I_CLK_SYS) flags_q[0]);
    c_po: cover property (@(posedge I_CLK_SYS) $rose(po_done_q));
endmodule

/* testbench/sfr_ctrl_model.sv */
// controller-side decoder: turns the manager's output code into a class
// assumes mode and duty come straight from the manager, same clock
`timescale 1ns/100ps
module sfr_ctrl_model (
    // clock
    input  wire logic       i_clk,
    // line as the controller sees it
    input  wire logic [1:0] i_mode,
    input  wire logic [9:0] i_duty,
    // decoded result, one edge late
    output logic [2:0]      o_class,
    output logic            o_hiz
);
    // a released line decodes as no class; unknown duty also reads as 0
    always_ff @(posedge i_clk) begin
        o_hiz <= (i_mode == 2'h2);
        if (i_mode != 2'h1) begin
            o_class <= 3'h0;
        end else begin
            case (i_duty)
                10'h194: o_class <= 3'h1;
                10'h074: o_class <= 3'h2;
                10'h134: o_class <= 3'h3;
                10'h1f4: o_class <= 3'h4;
                10'h254: o_class <= 3'h5;
                10'h2b4: o_class <= 3'h6;
                10'h314: o_class <= 3'h7;
                default: o_class <= 3'h0;
            endcase
        end
    end
endmodule

/* testbench/sfr_fault_mgr_tb.sv */
// self-checking bench for the fault response manager
// assumes header and package compiled first; short hold and delay counts
`timescale 1ns/100ps
`include "sfr_cfg.svh"
module sfr_fault_mgr_tb;
    localparam int UVH = 16;
    localparam int PO  = 8;
    logic                 clk = 1'h0;
    logic                 rst = 1'h1;
    sfr_pkg::sfr_faults_t flt = '0;
    logic [25:0]          mdat = 26'h0;
    logic                 mval = 1'h0;
    logic [1:0]           mode, bresp, rresp, rsp;
    logic [9:0]           duty;
    logic [3:0]           nib;
    logic                 prog, mreq, hiz;
    logic [2:0]           cls;
    logic [11:0]          awaddr = 12'h0, araddr = 12'h0;
    logic                 awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic                 arvalid = 1'h0, rready = 1'h0;
    logic [31:0]          wdata = 32'h0, rdata, rd;
    logic                 awready, wready, bvalid, arready, rvalid;
    int                   n_mismatch = 0;
    int                   checked = 0;
    int                   n_req = 0;

    always #5 clk = ~clk;
    // request pulses are counted here since their edge is not fixed
    always @(posedge clk) if (mreq === 1'h1) n_req++;

    sfr_fault_mgr #(.UV_HOLD_CYC(UVH), .PO_CYC(PO)) sfr_fault_mgr_inst (
        .I_CLK_SYS(clk), .I_RST(rst), .I_FAULTS(flt),
        .I_MEM_DATA(mdat), .I_MEM_VALID(mval),
        .O_OUT_MODE(mode), .O_DUTY_CODE(duty),
        .O_SENT_STATUS_NIBBLE(nib), .O_PROG_MODE(prog),
        .O_MEM_RD_REQ(mreq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    sfr_ctrl_model sfr_ctrl_model_inst (
        .i_clk(clk), .i_mode(mode), .i_duty(duty),
        .o_class(cls), .o_hiz(hiz));

    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one write; each channel is released at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid === 1'h1) break;
        end
        if (i == 50) begin
            n_mismatch++;
            stop_test;
        end else begin
            rsp = bresp;
            bready <= 1'h0;
            @(posedge clk);
        end
    endtask

    task automatic rdr(input logic [11:0] a);
        int i;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid === 1'h1) break;
        end
        if (i == 50) begin
            n_mismatch++;
            stop_test;
        end else begin
            rd = rdata;
            rsp = rresp;
            rready <= 1'h0;
            @(posedge clk);
        end
    endtask

    task automatic do_reset;
        rst <= 1'h1;
        flt <= '0;
        cyc(4);
        rst <= 1'h0;
        cyc(3);
        chk("mode early", mode, 32'h2);
        cyc(PO + 6);
        chk("mode late", mode, 32'h0);
        rdr(`SFR_OFF_CFG);
        chk("cfg reset", rd, 32'h200);
        rdr(`SFR_OFF_FLAGS);
        chk("flags reset", rd, 32'h0);
    endtask

    // read-only flags ignore writes; unmapped places answer with an error
    task automatic t_bus;
        wr(`SFR_OFF_FLAGS, 32'hff);
        rdr(`SFR_OFF_FLAGS);
        chk("flags ro", rd, 32'h0);
        rdr(12'h100);
        chk("rd unmapped", rsp, 32'h2);
        wr(12'h100, 32'h1);
        chk("wr unmapped", rsp, 32'h2);
    endtask

    task automatic t_uv;
        flt.uv <= 1'h1;
        cyc(4);
        chk("uv mode", mode, 32'h1);
        chk("uv duty", duty, 32'h074);
        chk("uv nibble", nib, 32'h2);
        chk("uv class", cls, 32'h2);
        rdr(`SFR_OFF_FLAGS);
        chk("uv flag", rd[3], 32'h1);
        flt.uv <= 1'h0;
        cyc(4);
        chk("uv clear", mode, 32'h0);
    endtask

    // the held error must outlast the pipeline but not the hold count
    task automatic t_hold;
        wr(`SFR_OFF_CFG, 32'h220);
        flt.uv <= 1'h1;
        cyc(4);
        flt.uv <= 1'h0;
        cyc(4);
        chk("uv held", mode, 32'h1);
        cyc(UVH + 4);
        chk("uv released", mode, 32'h0);
        wr(`SFR_OFF_CFG, 32'h200);
    endtask

    task automatic t_table;
        logic [9:0] dty[5] = '{10'h134, 10'h1f4, 10'h254, 10'h2b4, 10'h314};
        int         sh[5] = '{4, 6, 5, 3, 2};
        int         fb[5] = '{2, 5, 5, 6, 7};
        for (int k = 0; k < 5; k++) begin
            flt <= sfr_pkg::sfr_faults_t'(11'h1 << sh[k]);
            cyc(4);
            chk("tbl mode", mode, 32'h1);
            chk("tbl duty", duty, {22'h0, dty[k]});
            chk("tbl class", cls, k + 3);
            chk("tbl nibble", nib, (k == 0) ? 32'h1 : 32'h2);
            rdr(`SFR_OFF_FLAGS);
            chk("tbl flag", rd[fb[k]], 32'h1);
            flt <= '0;
            cyc(4);
        end
    endtask

    task automatic t_ov;
        flt.ov <= 1'h1;
        cyc(4);
        chk("prog mode", prog, 32'h1);
        chk("prog hiz", mode, 32'h2);
        wr(`SFR_OFF_CFG, 32'hc200);
        cyc(4);
        chk("ov mode", mode, 32'h1);
        chk("ov duty", duty, 32'h194);
        chk("ov prog", prog, 32'h0);
        rdr(`SFR_OFF_FLAGS);
        chk("ov flag", rd[4], 32'h1);
        wr(`SFR_OFF_CFG, 32'h6200);
        cyc(4);
        chk("lock6 prog", prog, 32'h1);
        chk("lock6 hiz", mode, 32'h2);
        wr(`SFR_OFF_CFG, 32'hc201);
        cyc(4);
        chk("ov off", mode, 32'h0);
        flt.hv <= 1'h1;
        cyc(1);
        #1 chk("hv wait", mode, 32'h0);
        cyc(1);
        #1 chk("hv hiz", mode, 32'h2);
        @(posedge clk);
        flt <= '0;
        wr(`SFR_OFF_CFG, 32'h200);
        cyc(4);
    endtask

    task automatic t_resp;
        wr(`SFR_OFF_CFG, 32'h210);
        flt.uv <= 1'h1;
        cyc(4);
        chk("resp hiz", mode, 32'h2);
        chk("resp line", hiz, 32'h1);
        flt <= '0;
        wr(`SFR_OFF_CFG, 32'h204);
        flt.ot <= 1'h1;
        cyc(4);
        chk("temp off", mode, 32'h0);
        flt <= '0;
        wr(`SFR_OFF_CFG, 32'h200);
        flt.por <= 1'h1;
        flt.uv <= 1'h1;
        cyc(4);
        chk("por hiz", mode, 32'h2);
        flt.por <= 1'h0;
        cyc(4);
        chk("por uv", mode, 32'h1);
        flt <= '0;
        cyc(PO + 6);
        chk("por done", mode, 32'h0);
    endtask

    task automatic mem_pulse(input logic [25:0] d, input logic s, e);
        mdat <= d;
        flt.sec <= s;
        flt.ded <= e;
        mval <= 1'h1;
        @(posedge clk);
        mval <= 1'h0;
        flt.sec <= 1'h0;
        flt.ded <= 1'h0;
        cyc(3);
    endtask

    // the double error is sticky, so it goes last before a new reset
    task automatic t_mem;
        wr(`SFR_OFF_MEMCTL, 32'h1);
        cyc(10);
        chk("mem req", n_req, 32'h1);
        mem_pulse(26'h2ab_cdef, 1'h1, 1'h0);
        chk("sec mode", mode, 32'h0);
        rdr(`SFR_OFF_MEMRESP);
        chk("mem sec", rd, 32'h12ab_cdef);
        mem_pulse(26'h3ff_ffff, 1'h0, 1'h0);
        rdr(`SFR_OFF_MEMRESP);
        chk("mem clean", rd, 32'h03ff_ffff);
        mem_pulse(26'h0, 1'h0, 1'h1);
        chk("ded hiz", mode, 32'h2);
        rdr(`SFR_OFF_MEMRESP);
        chk("mem ded", rd, 32'h2000_0000);
        rdr(`SFR_OFF_FLAGS);
        chk("ded flag", rd[0], 32'h1);
    endtask

    initial begin
        do_reset;
        t_bus;
        t_uv;
        t_hold;
        t_table;
        t_ov;
        t_resp;
        t_mem;
        do_reset;
        stop_test;
    end
endmodule
